// File: src/wdrt_defs.vh
// Constants for the watchdog reset timer: register offsets, field positions,
// reset values and timing counts. Assumes inclusion by bare name.
`ifndef WDRT_DEFS_VH
`define WDRT_DEFS_VH

`define WDRT_ADDR_W           8
`define WDRT_OFF_WDOG_CTRL    8'h9F
`define WDRT_OFF_SYS_CFG      8'hBF
`define WDRT_ADDR_WDOG_CTRL   10'h27C
`define WDRT_ADDR_SYS_CFG     10'h2FC
`define WDRT_BYTE_ADDR_W      10

`define WDRT_BIT_ENABLE       7
`define WDRT_BIT_CLEAR        5
`define WDRT_DIVSEL_HI        2
`define WDRT_DIVSEL_LO        0
`define WDRT_BIT_RESET_FLAG   7
`define WDRT_BIT_LATCH_INH    0

`define WDRT_CTRL_RST         8'h00
`define WDRT_CFG_RST          8'h00

`define WDRT_CNT_W            16
`define WDRT_DIV_W            10
`define WDRT_DIV_MIN          11'h008
`define WDRT_STROBE_DIV       3'h6
`define WDRT_RESET_PULSE      4'h4

`define WDRT_RESP_OKAY        2'h0
`define WDRT_RESP_SLVERR      2'h2

`endif

// File: src/wdrt_prescaler.v
// Programmable prescaler producing a one-cycle tick every 8 to 1024 clocks.
// Assumes a single clock domain and a synchronous active-low clear.
`include "wdrt_defs.vh"

module wdrt_prescaler #(
   parameter DIV_W = `WDRT_DIV_W
)(
   input  wire        core_clk_i,
   input  wire        clr_n_i,
   input  wire        run_i,
   input  wire [2:0]  sel_i,
   output wire        tick_o
);

   reg  [DIV_W-1:0] cnt_q;
   wire [DIV_W:0]   div_w;
   wire [DIV_W-1:0] last_w;

   // Code 000 gives 8 and each step doubles, so code 111 gives 1024.
   assign div_w  = `WDRT_DIV_MIN << sel_i;
   assign last_w = div_w[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1};
   assign tick_o = run_i && (cnt_q == last_w);

   // Counts clocks while running and wraps at the selected divider.
   always @(posedge core_clk_i)
   begin
      if (!clr_n_i || !run_i || tick_o)
         cnt_q <= {DIV_W{1'b0}};
      else
         cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
   end

endmodule

// File: src/wdrt_strobe_gen.v
// Address latch strobe generator: pulses high for one clock in every six.
// Assumes one clock domain; the inhibit input comes from a register.
`include "wdrt_defs.vh"

module wdrt_strobe_gen (
   input  wire core_clk_i,
   input  wire rst_n_i,
   input  wire inhibit_i,
   output reg  strobe_o
);

   reg [2:0] phase_q;

   // Produces one high clock out of every six, held low while inhibited.
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         phase_q  <= 3'h0;
         strobe_o <= 1'b0;
      end
      else
      begin
         if (phase_q == `WDRT_STROBE_DIV - 3'h1)
            phase_q <= 3'h0;
         else
            phase_q <= phase_q + 3'h1;
         strobe_o <= !inhibit_i && (phase_q == 3'h0); // R8
      end
   end

endmodule

// File: src/wdrt_top.v
// Watchdog reset timer with its control and configuration registers on
// AXI4-Lite, plus the divided-by-six address latch strobe.
// Assumes the chip reset sequencer honours wdog_reset_o, that the bus runs on
// core_clk_i, and that rst_n_i is already synchronous to core_clk_i.
// The counter width is a parameter so that short runs can reach an overflow;
// the default is the full sixteen bits.
//
// Implementation choice: the AXI4-Lite slave port.
`include "wdrt_defs.vh"

// Operation
// R1: A 16-bit counter runs up and its overflow resets the whole device.
// R2: The counter stays idle until software sets the enable bit, then counts divided ticks.
// R3: The three-bit divider select picks 8 for code 000, doubling to 1024 for code 111.
// R4: Any reset, external or watchdog, clears the enable bit.
// R5: Writing 1 to the clear bit zeroes the counter so it restarts from zero.
// R6: Software must clear the counter more often than the chosen timeout.
// R7: A watchdog overflow reset sets the reset flag in the system configuration register.
// R8: The latch strobe inhibit bit suppresses the divided-by-six strobe output.
// R9: The clear bit is a self-clearing strobe that always reads back as 0.
module wdrt_top #(
   parameter RESET_PULSE = `WDRT_RESET_PULSE,
   parameter CNT_W       = `WDRT_CNT_W
)(
   // Clock and synchronous reset.
   input  wire        core_clk_i,
   input  wire        rst_n_i,
   // Write address channel.
   input  wire [9:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   // Write data channel; only byte lane 0 carries a register.
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   // Write response channel.
   output reg  [1:0]  s_axi_bresp_o,
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   // Read address channel.
   input  wire [9:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   // Read data channel.
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   // Chip reset request and address latch strobe.
   output reg         wdog_reset_o,
   output wire        latch_strobe_o
);

   // Register fields.
   reg                   enable_q;
   reg  [2:0]            divsel_q;
   reg                   reset_flag_q;
   reg                   latch_inh_q;
   reg                   clear_stb_q;

   // Watchdog count and reset pulse stretcher.
   reg  [CNT_W-1:0]      count_q;
   reg  [3:0]            pulse_q;
   wire                  tick_w;
   wire                  overflow_w;
   wire                  blk_rst_n_w;

   // Write channel holding registers.
   reg                   aw_held_q;
   reg  [9:0]            aw_addr_q;
   reg                   w_held_q;
   reg  [31:0]           w_data_q;
   reg  [3:0]            w_strb_q;

   // Address decode and read views.
   wire                  do_write_w;
   wire                  hit_ctrl_w;
   wire                  hit_cfg_w;
   wire                  ctrl_we_w;
   wire                  cfg_we_w;
   wire [7:0]            ctrl_rd_w;
   wire [7:0]            cfg_rd_w;
   reg  [7:0]            rd_byte_d;
   reg  [1:0]            rd_resp_d;

   // Block-level reset: the external reset or our own overflow pulse.
   // The bus and the configuration register see only the external reset, so the
   // reset flag and a pending bus answer survive a watchdog reset.
   assign blk_rst_n_w = rst_n_i && !wdog_reset_o;

   // Write channels are accepted independently and held until both arrive.
   // Both readies stay low while a response waits, so one write at most is open.
   assign s_axi_awready_o = !aw_held_q && !s_axi_bvalid_o;
   assign s_axi_wready_o  = !w_held_q && !s_axi_bvalid_o;
   assign s_axi_arready_o = !s_axi_rvalid_o;
   assign do_write_w      = aw_held_q && w_held_q && !s_axi_bvalid_o;
   assign hit_ctrl_w      = (aw_addr_q == `WDRT_ADDR_WDOG_CTRL);
   assign hit_cfg_w       = (aw_addr_q == `WDRT_ADDR_SYS_CFG);

   // Register write enables; a write without byte lane 0 changes nothing.
   assign ctrl_we_w = do_write_w && hit_ctrl_w && w_strb_q[0];
   assign cfg_we_w  = do_write_w && hit_cfg_w && w_strb_q[0];

   // Read views; the clear bit and unused bits always read as zero.
   assign ctrl_rd_w = {enable_q, 1'b0, 1'b0, 2'b00, divsel_q}; // R9
   assign cfg_rd_w  = {reset_flag_q, 6'h00, latch_inh_q};

   // Read decode: mapped registers answer OKAY, any other address answers
   // SLVERR with zero data and no side effect.
   always @*
   begin
      rd_byte_d = 8'h00;
      rd_resp_d = `WDRT_RESP_SLVERR;
      case (s_axi_araddr_i)
         `WDRT_ADDR_WDOG_CTRL:
         begin
            rd_byte_d = ctrl_rd_w;
            rd_resp_d = `WDRT_RESP_OKAY;
         end
         `WDRT_ADDR_SYS_CFG:
         begin
            rd_byte_d = cfg_rd_w;
            rd_resp_d = `WDRT_RESP_OKAY;
         end
         default:
         begin
            rd_byte_d = 8'h00;
            rd_resp_d = `WDRT_RESP_SLVERR;
         end
      endcase
   end

   // Address and data capture for the write channels.
   // Either channel may arrive first; each is held until the register write
   // fires, which is the edge after both are held.
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 10'h000;
         w_held_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end
         else if (do_write_w)
            aw_held_q <= 1'b0;
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
         end
         else if (do_write_w)
            w_held_q <= 1'b0;
      end
   end

   // Write response: OKAY for mapped registers, SLVERR elsewhere.
   // The response rises on the edge that performs the write, so it follows
   // both channels by one clock.
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= `WDRT_RESP_OKAY;
      end
      else if (do_write_w)
      begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= (hit_ctrl_w || hit_cfg_w) ? `WDRT_RESP_OKAY : `WDRT_RESP_SLVERR;
      end
      else if (s_axi_bready_i)
         s_axi_bvalid_o <= 1'b0;
   end

   // Read response: register data one cycle after the address is taken.
   // Data and response are registered so they stand unchanged until rready.
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= `WDRT_RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o  <= {24'h000000, rd_byte_d};
         s_axi_rresp_o  <= rd_resp_d;
      end
      else if (s_axi_rready_i)
         s_axi_rvalid_o <= 1'b0;
   end

   // Watchdog control register; any reset drops the enable bit.
   // The clear bit lives for one cycle only, so it always reads back as zero and
   // a second clear needs no write of zero in between.
   always @(posedge core_clk_i)
   begin
      if (!blk_rst_n_w)
      begin
         enable_q    <= 1'b0; // R4
         divsel_q    <= 3'h0;
         clear_stb_q <= 1'b0;
      end
      else
      begin
         clear_stb_q <= 1'b0; // R9
         if (ctrl_we_w)
         begin
            enable_q    <= w_data_q[`WDRT_BIT_ENABLE]; // R2
            divsel_q    <= w_data_q[`WDRT_DIVSEL_HI:`WDRT_DIVSEL_LO]; // R3
            clear_stb_q <= w_data_q[`WDRT_BIT_CLEAR]; // R5
         end
      end
   end

   // System configuration: the reset flag survives the watchdog reset itself.
   // An overflow in the same cycle as a software write leaves the flag set.
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         reset_flag_q <= 1'b0;
         latch_inh_q  <= 1'b0;
      end
      else
      begin
         if (cfg_we_w)
         begin
            latch_inh_q  <= w_data_q[`WDRT_BIT_LATCH_INH]; // R8
            reset_flag_q <= w_data_q[`WDRT_BIT_RESET_FLAG];
         end
         if (overflow_w)
            reset_flag_q <= 1'b1; // R7
      end
   end

   // Divided time base; idle while disabled or being cleared.
   // Clearing it with the counter keeps the first period after a clear full length.
   wdrt_prescaler #(
      .DIV_W (`WDRT_DIV_W)
   ) u_prescaler (
      .core_clk_i (core_clk_i),
      .clr_n_i    (blk_rst_n_w && !clear_stb_q),
      .run_i      (enable_q),
      .sel_i      (divsel_q),
      .tick_o     (tick_w)
   );

   // Overflow is the tick that would carry the counter past its top value,
   // so the timeout is two to the power CNT_W ticks.
   assign overflow_w = tick_w && (count_q == {CNT_W{1'b1}}); // R1

   // Counter: cleared by reset or the clear strobe, advanced by ticks.
   // A clear and a tick in one cycle leave the counter at zero.
   always @(posedge core_clk_i)
   begin
      if (!blk_rst_n_w || clear_stb_q)
         count_q <= {CNT_W{1'b0}}; // R5
      else if (tick_w)
         count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1}; // R2
   end

   // Overflow stretches into a fixed-length reset pulse for the chip.
   // The pulse lasts RESET_PULSE clocks and also resets this block's own
   // watchdog state through blk_rst_n_w.
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         pulse_q      <= 4'h0;
         wdog_reset_o <= 1'b0;
      end
      else if (overflow_w)
      begin
         pulse_q      <= RESET_PULSE[3:0] - 4'h1;
         wdog_reset_o <= 1'b1; // R1
      end
      else if (pulse_q != 4'h0)
         pulse_q <= pulse_q - 4'h1;
      else
         wdog_reset_o <= 1'b0;
   end

   // Address latch strobe, held low while the inhibit bit is set; it sees the
   // external reset only, so a watchdog reset does not disturb its rhythm.
   wdrt_strobe_gen u_strobe (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .inhibit_i  (latch_inh_q),
      .strobe_o   (latch_strobe_o)
   );

endmodule

// File: dv/wdrt_checker.sv
// Port checker for the watchdog reset timer.
// Assumes one clock and a synchronous active-low reset.
module wdrt_checker #(
   parameter RESET_PULSE = 4
)(
   input wire        core_clk_i,
   input wire        rst_n_i,
   input wire        s_axi_awready_o,
   input wire [1:0]  s_axi_bresp_o,
   input wire        s_axi_bvalid_o,
   input wire        s_axi_bready_i,
   input wire        s_axi_arvalid_i,
   input wire        s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o,
   input wire        s_axi_rvalid_o,
   input wire        s_axi_rready_i,
   input wire        wdog_reset_o,
   input wire        latch_strobe_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Strobe pulses are one clock in six; reset pulses have a fixed length.
   a_strobe_gap: assert property (latch_strobe_o |=> !latch_strobe_o [*5])
      else $error("strobe pulses too close");
   a_reset_len: assert property ($rose(wdog_reset_o) |-> wdog_reset_o [*4] ##1 !wdog_reset_o)
      else $error("reset pulse length wrong");
   // Bus handshakes and response timing.
   a_b_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
      else $error("write response repeated");
   a_r_done: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("read response repeated");
   a_r_latency: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   a_aw_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
      else $error("address taken with response pending");
   a_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read taken with data pending");
   a_rdata_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
      else $error("upper read bits not zero");

   // Main scenarios seen.
   c_strobe: cover property (latch_strobe_o);
   c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
   c_flag: cover property (s_axi_rvalid_o && s_axi_rdata_o[7]);
   c_wdog: cover property ($rose(wdog_reset_o));
endmodule

bind wdrt_top wdrt_checker #(.RESET_PULSE(RESET_PULSE)) u_wdrt_checker (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
   .wdog_reset_o(wdog_reset_o), .latch_strobe_o(latch_strobe_o));

// File: dv/watchdog_reset_timer_test.sv
// Self-checking bench for the watchdog reset timer.
// Assumes the register map constants of the shared header.
`include "wdrt_defs.vh"

module watchdog_reset_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [9:0] CT = `WDRT_ADDR_WDOG_CTRL;
   localparam [9:0] CF = `WDRT_ADDR_SYS_CFG;
   localparam [1:0] OK = `WDRT_RESP_OKAY;
   localparam [1:0] ER = `WDRT_RESP_SLVERR;
   logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
   logic [9:0]  awaddr = 10'h0, araddr = 10'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, wdog, strobe;
   int          fails = 0, num_checks = 0, n;

   // The clock runs at 25 MHz.
   always #20 clk = ~clk;

   // Design under test; both ready inputs stay high and the counter is four
   // bits wide, so a timeout is 16 ticks of the selected divider.
   wdrt_top #(.RESET_PULSE(4), .CNT_W(4)) u_wdrt_top (
      .core_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(1'b1), .wdog_reset_o(wdog), .latch_strobe_o(strobe));

   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Write: address and data offered together, each released when taken.
   task wr(input [9:0] a, input [7:0] d, input [1:0] er);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge clk);
         ad = ad | (awv & awready);
         wd = wd | (wv & wready);
         awv <= awv & ~awready;
         wv <= wv & ~wready;
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      chk("bresp", bresp, er);
   endtask

   task rd(input [9:0] a, input [7:0] d, input [1:0] er);
      araddr <= a;
      arv <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      chk("rdata", rdata, {24'h0, d});
      chk("rresp", rresp, er);
   endtask

   // Counts strobe pulses over sixty clocks.
   task cnt(input int e);
      n = 0;
      repeat (60) @(posedge clk) n += strobe;
      chk("strobes", n, e);
   endtask

   task t_regs;
      rd(CT, 8'h00, OK);
      rd(CF, 8'h00, OK);
      for (int c = 0; c < 8; c++)
      begin
         wr(CT, {5'b10000, c[2:0]}, OK);
         rd(CT, {5'b10000, c[2:0]}, OK);
      end
      wr(CT, 8'hA3, OK);
      rd(CT, 8'h83, OK);
      wr(CT, 8'hA3, OK);
      rd(CT, 8'h83, OK);
      chk("wdog", wdog, 0);
      wr(CF, 8'h80, OK);
      rd(CF, 8'h80, OK);
      wr(CF, 8'h00, OK);
      wr(10'h100, 8'h55, ER);
      rd(10'h100, 8'h00, ER);
      rd(CT, 8'h83, OK);
   endtask

   task t_strobe;
      wr(CF, 8'h01, OK);
      repeat (2) @(posedge clk);
      cnt(0);
      wr(CF, 8'h00, OK);
      repeat (6) @(posedge clk);
      cnt(10);
   endtask

   // An external reset in mid-run clears the enable bit.
   task t_reset;
      wr(CT, 8'h85, OK);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(CT, 8'h00, OK);
   endtask

   // Enables with a clear and lets the counter run out: no reset before the
   // timeout t, then one pulse of four clocks, the enable bit dropped and the flag set.
   task runout(input [7:0] d, input int t);
      wr(CT, d, OK);
      n = 0;
      repeat (t - 8) @(posedge clk) n += wdog;
      chk("wdog_early", n, 0);
      repeat (20) @(posedge clk) n += wdog;
      chk("wdog_pulse", n, 4);
      rd(CT, 8'h00, OK);
      rd(CF, 8'h80, OK);
      wr(CF, 8'h00, OK);
   endtask

   // Clears about every 63 clocks hold off a 128-clock timeout, then two run-outs.
   task t_wdog;
      wr(CT, 8'hA0, OK);
      n = 0;
      repeat (4)
      begin
         repeat (60) @(posedge clk) n += wdog;
         wr(CT, 8'hA0, OK);
      end
      chk("wdog_held", n, 0);
      runout(8'hA0, 128);
      runout(8'hA1, 256);
      rd(CF, 8'h00, OK);
   endtask

   task end_sim;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence after five reset cycles.
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs;
      t_strobe;
      t_reset;
      t_wdog;
      end_sim;
   end

   // Cuts a hang short.
   initial
   begin
      #400000;
      fails++;
      end_sim;
   end
endmodule
